// >>> src/sfcu_pkg.sv
// constants and types for the subtract-from datapath
package sfcu_pkg;
    // ------------------------------------------------------------
    // instruction fields, bit 0 is the word's least significant bit
    // ------------------------------------------------------------
    localparam int PRIMARY_OP = 31;
    localparam int EXT_SUB_PLAIN = 40;
    localparam int EXT_SUB_CARRY = 8;
    localparam int EXT_SUB_EXTEND = 136;
    localparam int POS_PRIMARY_LSB = 26;
    localparam int POS_TARGET_LSB = 21;
    localparam int POS_SRC1_LSB = 16;
    localparam int POS_SRC2_LSB = 11;
    localparam int POS_OV_ENABLE = 10;
    localparam int POS_EXT_LSB = 1;
    localparam int POS_RECORD = 0;
    localparam logic [31:0] RESET_RESULT = 32'h0000_0000;
    localparam logic [3:0] RESET_CR0 = 4'h0;
    localparam logic RESET_STROBE = 1'b0;
    localparam logic [4:0] RESET_TARGET = 5'h00;

    typedef enum {SFCU_OP_NONE, SFCU_OP_PLAIN, SFCU_OP_CARRY, SFCU_OP_EXTEND} sfcu_op_t;

    typedef struct packed {
        logic carry_flag;
        logic overflow_flag;
        logic summary_overflow;
    } sfcu_xer_t;

    localparam sfcu_xer_t RESET_XER = 3'h0;

    typedef struct packed {
        logic less_than_zero_flag;
        logic greater_than_zero_flag;
        logic equal_zero_flag;
        logic summary_overflow;
    } sfcu_cr0_t;
endpackage

// >>> src/sfcu_unit.sv
// subtract-from datapath: decode, sum, flag and condition field update
module sfcu_unit (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_valid,
    input wire logic [31:0] i_instr,
    input wire logic [31:0] i_source_one,
    input wire logic [31:0] i_source_two,
    input wire sfcu_pkg::sfcu_xer_t i_xer,
    output logic o_write,
    output logic [4:0] o_target_reg_index,
    output logic [31:0] o_result,
    output logic [4:0] o_source_one_index,
    output logic [4:0] o_source_two_index,
    output logic o_xer_carry_write,
    output logic o_xer_ov_write,
    output sfcu_pkg::sfcu_xer_t o_xer,
    output logic o_cr0_write,
    output sfcu_pkg::sfcu_cr0_t o_cr0,
    output logic o_illegal
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [5:0] primary;
    logic [8:0] ext;
    logic ov_enable;
    logic record_bit;
    sfcu_pkg::sfcu_op_t op;

    assign primary = i_instr[sfcu_pkg::POS_PRIMARY_LSB +: 6];
    assign ext = i_instr[sfcu_pkg::POS_EXT_LSB +: 9];
    assign ov_enable = i_instr[sfcu_pkg::POS_OV_ENABLE];
    assign record_bit = i_instr[sfcu_pkg::POS_RECORD];
    // register file reads the sources combinationally
    assign o_source_one_index = i_instr[sfcu_pkg::POS_SRC1_LSB +: 5];
    assign o_source_two_index = i_instr[sfcu_pkg::POS_SRC2_LSB +: 5];

    always_comb begin
        op = sfcu_pkg::SFCU_OP_NONE;
        if (primary == 6'(sfcu_pkg::PRIMARY_OP)) begin
            case (ext)
                9'(sfcu_pkg::EXT_SUB_PLAIN): op = sfcu_pkg::SFCU_OP_PLAIN;
                9'(sfcu_pkg::EXT_SUB_CARRY): op = sfcu_pkg::SFCU_OP_CARRY;
                9'(sfcu_pkg::EXT_SUB_EXTEND): op = sfcu_pkg::SFCU_OP_EXTEND;
                default: op = sfcu_pkg::SFCU_OP_NONE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // adder
    // ------------------------------------------------------------
    logic carry_in;
    logic [31:0] inv_one;
    logic [31:0] src_two;
    logic [32:0] carry_chain;
    logic [31:0] sum;
    logic next_carry;
    logic next_ov;
    logic next_so;

    // plain and carrying forms inject one, extended injects the carry flag
    assign carry_in = (op == sfcu_pkg::SFCU_OP_EXTEND) ? i_xer.carry_flag : 1'b1;
    assign inv_one = ~i_source_one;
    assign src_two = i_source_two;
    assign carry_chain[0] = carry_in;

    // plain ripple: ample at this clock, and its top two carries give overflow cheaply
    for (genvar b = 0; b < 32; b++) begin : g_bit
        assign sum[b] = inv_one[b] ^ src_two[b] ^ carry_chain[b];
        assign carry_chain[b + 1] = (inv_one[b] & src_two[b]) | (carry_chain[b] & (inv_one[b] ^ src_two[b]));
    end

    // ------------------------------------------------------------
    // flags
    // ------------------------------------------------------------
    logic result_is_zero;
    sfcu_pkg::sfcu_cr0_t next_cr0;

    // plain subtract hands the incoming carry flag back untouched
    assign next_carry = (op == sfcu_pkg::SFCU_OP_PLAIN) ? i_xer.carry_flag : carry_chain[32];
    // signed overflow: carries into and out of the sign bit disagree
    assign next_ov = carry_chain[31] ^ carry_chain[32];
    // summary only accumulates, never cleared here
    assign next_so = ov_enable ? (i_xer.summary_overflow | next_ov) : i_xer.summary_overflow;
    assign result_is_zero = (sum == 32'h0000_0000);

    always_comb begin
        next_cr0.less_than_zero_flag = sum[31];
        next_cr0.greater_than_zero_flag = !sum[31] && !result_is_zero;
        next_cr0.equal_zero_flag = result_is_zero;
        // copy reflects this instruction's own overflow update
        next_cr0.summary_overflow = next_so;
    end

    // ------------------------------------------------------------
    // acceptance
    // ------------------------------------------------------------
    logic hit;
    logic refused;

    assign hit = i_valid && (op != sfcu_pkg::SFCU_OP_NONE);
    // unknown words are flagged and never written
    assign refused = i_valid && (op == sfcu_pkg::SFCU_OP_NONE);

    // ------------------------------------------------------------
    // strobes, high for one cycle after the taking edge
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_write <= sfcu_pkg::RESET_STROBE;
        end else begin
            o_write <= hit;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_illegal <= sfcu_pkg::RESET_STROBE;
        end else begin
            o_illegal <= refused;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_xer_carry_write <= sfcu_pkg::RESET_STROBE;
        end else begin
            // plain subtract leaves the carry flag alone in every form
            o_xer_carry_write <= hit && (op != sfcu_pkg::SFCU_OP_PLAIN);
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_xer_ov_write <= sfcu_pkg::RESET_STROBE;
        end else begin
            o_xer_ov_write <= hit && ov_enable;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cr0_write <= sfcu_pkg::RESET_STROBE;
        end else begin
            o_cr0_write <= hit && record_bit;
        end
    end

    // ------------------------------------------------------------
    // data registers, held until the next accepted word (cr0 until the next accepted word with the record bit set)
    // ------------------------------------------------------------
    logic xer_carry;
    logic xer_ov;
    logic xer_so;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_target_reg_index <= sfcu_pkg::RESET_TARGET;
        end else if (hit) begin
            o_target_reg_index <= i_instr[sfcu_pkg::POS_TARGET_LSB +: 5];
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_result <= sfcu_pkg::RESET_RESULT;
        end else if (hit) begin
            o_result <= sum;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            xer_carry <= sfcu_pkg::RESET_XER.carry_flag;
        end else if (hit) begin
            xer_carry <= next_carry;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            xer_ov <= sfcu_pkg::RESET_XER.overflow_flag;
        end else if (hit) begin
            xer_ov <= ov_enable ? next_ov : i_xer.overflow_flag;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            xer_so <= sfcu_pkg::RESET_XER.summary_overflow;
        end else if (hit) begin
            xer_so <= next_so;
        end
    end

    // one flop per flag; the outgoing word only gathers them
    assign o_xer = {xer_carry, xer_ov, xer_so};

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cr0 <= sfcu_pkg::RESET_CR0;
        end else if (hit && record_bit) begin
            o_cr0 <= next_cr0;
        end
    end

    // ------------------------------------------------------------
    // field map sanity: the fields must tile the word edge to edge
    // ------------------------------------------------------------
    if (sfcu_pkg::POS_PRIMARY_LSB + 6 != 32) begin : g_bad_primary
        $error("primary opcode field does not end at the top bit");
    end
    if (sfcu_pkg::POS_TARGET_LSB + 5 != sfcu_pkg::POS_PRIMARY_LSB) begin : g_bad_target
        $error("target index field does not meet the primary opcode field");
    end
    if (sfcu_pkg::POS_SRC1_LSB + 5 != sfcu_pkg::POS_TARGET_LSB) begin : g_bad_src1
        $error("source one field does not meet the target index field");
    end
    if (sfcu_pkg::POS_SRC2_LSB + 5 != sfcu_pkg::POS_SRC1_LSB) begin : g_bad_src2
        $error("source two field does not meet the source one field");
    end
    if (sfcu_pkg::POS_OV_ENABLE + 1 != sfcu_pkg::POS_SRC2_LSB) begin : g_bad_ov
        $error("overflow enable bit does not meet the source two field");
    end
    if (sfcu_pkg::POS_EXT_LSB + 9 != sfcu_pkg::POS_OV_ENABLE) begin : g_bad_ext
        $error("extended opcode field does not meet the overflow enable bit");
    end
    if (sfcu_pkg::POS_RECORD + 1 != sfcu_pkg::POS_EXT_LSB) begin : g_bad_record
        $error("record bit does not meet the extended opcode field");
    end
endmodule // sfcu_unit

// >>> bench/sfcu_sva.sv
// port checker for the subtract-from datapath
module sfcu_sva (
    input wire logic i_mclk, i_reset_n, i_valid, o_write, o_xer_carry_write, o_xer_ov_write, o_cr0_write, o_illegal,
    input wire logic [31:0] i_instr, i_source_one, i_source_two, o_result,
    input wire logic [4:0] o_target_reg_index,
    input wire sfcu_pkg::sfcu_xer_t i_xer, o_xer,
    input wire sfcu_pkg::sfcu_cr0_t o_cr0
);
    wire logic p = i_instr[9:1] == 9'h028;
    wire logic e = i_instr[9:1] == 9'h088;
    wire logic k = i_instr[31:26] == 6'h1F && (p || e || i_instr[9:1] == 9'h008);
    // only the extended form folds in the incoming carry
    wire logic [32:0] s = {1'b0, ~i_source_one} + {1'b0, i_source_two} + 33'(e ? i_xer.carry_flag : 1'b1);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    sequence s_t; i_valid && k; endsequence
    property p_take; s_t |=> o_write && !o_illegal; endproperty
    a_take: assert property (p_take) else $error("lost");
    property p_refuse; i_valid && !k |=> o_illegal && !o_write; endproperty
    a_refuse: assert property (p_refuse) else $error("taken");
    property p_ca_wr; s_t |=> o_xer_carry_write == !$past(p); endproperty
    a_ca_wr: assert property (p_ca_wr) else $error("ca wr");
    property p_ov_wr; s_t |=> o_xer_ov_write == $past(i_instr[10]); endproperty
    a_ov_wr: assert property (p_ov_wr) else $error("ov wr");
    property p_cr_wr; s_t |=> o_cr0_write == $past(i_instr[0]); endproperty
    a_cr_wr: assert property (p_cr_wr) else $error("cr wr");
    property p_tgt; s_t |=> o_target_reg_index == $past(i_instr[25:21]); endproperty
    a_tgt: assert property (p_tgt) else $error("target");
    property p_sum; s_t |=> o_result == $past(s[31:0]); endproperty
    a_sum: assert property (p_sum) else $error("sum");
    property p_ca; s_t ##0 !p |=> o_xer.carry_flag == $past(s[32]); endproperty
    a_ca: assert property (p_ca) else $error("carry");
    property p_ov_hold; s_t ##0 !i_instr[10] |=> o_xer.overflow_flag == $past(i_xer.overflow_flag); endproperty
    a_ov_hold: assert property (p_ov_hold) else $error("ov held");
    property p_so; s_t ##0 i_xer.summary_overflow |=> o_xer.summary_overflow; endproperty
    a_so: assert property (p_so) else $error("so cleared");
    sequence s_rec; s_t ##0 i_instr[0]; endsequence
    property p_cr0;
        s_rec |=> o_cr0.less_than_zero_flag == $past(s[31]) && o_cr0.equal_zero_flag == ($past(s[31:0]) == 0);
    endproperty
    a_cr0: assert property (p_cr0) else $error("cr0");
endmodule // sfcu_sva
bind sfcu_unit sfcu_sva u_sva (.*);

// >>> bench/sfcu_rf.sv
// source register file model, reads only
module sfcu_rf (input wire logic [4:0] i_a, i_b, output logic [31:0] o_a, o_b);
    logic [31:0] mem [32];
    assign {o_a, o_b} = {mem[i_a], mem[i_b]};
endmodule // sfcu_rf

// >>> bench/tb_top.sv
// bench for the subtract-from datapath
module tb_top;
    timeunit 1ns; timeprecision 1ns;
    logic i_mclk = 0, i_reset_n = 0, i_valid = 0, o_write, o_xer_carry_write, o_xer_ov_write, o_cr0_write, o_illegal, v;
    logic [31:0] i_instr = 0, i_source_one, i_source_two, o_result, x, y;
    logic [4:0] o_target_reg_index, o_source_one_index, o_source_two_index;
    sfcu_pkg::sfcu_xer_t i_xer = 0, o_xer;
    sfcu_pkg::sfcu_cr0_t o_cr0, c = 0;
    logic [8:0] ops[4] = '{9'h008, 9'h028, 9'h088, 9'h009};
    logic [38:0] q[$];
    logic [32:0] m;
    int n_fail = 0, samples_checked = 0;
    integer seed = 32'hBFA1;
    always #20 i_mclk = ~i_mclk;
    sfcu_unit DUT (.*);
    sfcu_rf rf (.i_a(o_source_one_index), .i_b(o_source_two_index), .o_a(i_source_one), .o_b(i_source_two));
    task automatic check(input logic [38:0] seen, exp);
        samples_checked++;
        if (seen !== exp) n_fail++;
        if (seen !== exp) $display("Error result_flags exp %h seen %h", exp, seen);
    endtask
    task automatic stop_test;
        $display("%0d checks %0d errors", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(negedge i_mclk) if (o_write === 1'b1) check({o_result, o_xer, o_cr0}, q.pop_front());
    initial begin
        repeat (700) @(negedge i_mclk);
        n_fail++;
        stop_test();
    end
    initial begin
        for (int i = 0; i < 32; i++) rf.mem[i] = $random(seed);
        repeat (20) @(negedge i_mclk);
        i_reset_n = 1;
        // back to back words; flags come fresh from the bench each cycle
        for (int i = 0; i < 600; i++) begin
            i_xer = 3'($random(seed));
            i_instr = {6'h1F, 16'($random(seed)), ops[i % 4], 1'($random(seed))};
            x = rf.mem[i_instr[20:16]];
            y = rf.mem[i_instr[15:11]];
            m = {1'b0, ~x} + {1'b0, y} + 33'(i % 4 == 2 ? i_xer.carry_flag : 1'b1);
            v = i_instr[10] && x[31] != y[31] && m[31] != y[31];
            if (i_instr[0] && i % 4 != 3)
                c = {m[31], !m[31] && m[31:0] != 0, m[31:0] == 0, i_xer.summary_overflow | v};
            if (i % 4 != 3) q.push_back({m[31:0], i % 4 == 1 ? i_xer.carry_flag : m[32],
                i_instr[10] ? v : i_xer.overflow_flag, i_xer.summary_overflow | v, c});
            i_valid = 1;
            @(negedge i_mclk);
        end
        i_valid = 0;
        repeat (2) @(negedge i_mclk);
        check(39'(q.size()), 39'h0);
        stop_test();
    end
endmodule // tb_top
